// file: rtl/byp_packer.sv
// Pair FIFO and the YUV 4:2:2 converter and byte packer top level

// ----------------------------------------------------------------------
// FIFO with valid and ready on both sides
// ----------------------------------------------------------------------
module byp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             wr;
    logic             rd;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign level     = count_r;

    // Pointer and occupancy update
    always_comb begin
        wr         = in_valid && in_ready;
        rd         = out_valid && out_ready;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (wr)
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
        if (rd)
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
        if (wr && !rd)
            count_nxt = count_r + 1'b1;
        else if (rd && !wr)
            count_nxt = count_r - 1'b1;
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // Storage array
    always_ff @(posedge clk) begin
        if (wr)
            mem[wr_ptr_r] <= in_data;
    end
endmodule // byp_fifo

// ----------------------------------------------------------------------
// Converter and packer
// ----------------------------------------------------------------------
module byp_packer (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       pix_valid,
    output logic                            pix_ready,
    input  wire logic                       pix_sof,
    input  wire logic [7:0]                 pix_red,
    input  wire logic [7:0]                 pix_green,
    input  wire logic [7:0]                 pix_blue,
    input  wire logic                       fmt_luma_first,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [byp_pkg::BYTE_W-1:0]      out_byte
);
    import byp_pkg::*;

    logic            in_vld_r, in_vld_nxt;
    logic            in_sof_r, in_sof_nxt;
    logic [7:0]      in_red_r, in_red_nxt;
    logic [7:0]      in_grn_r, in_grn_nxt;
    logic [7:0]      in_blu_r, in_blu_nxt;
    logic            odd_r, odd_nxt;
    logic [7:0]      hold_y_r, hold_y_nxt;
    logic [7:0]      hold_u_r, hold_u_nxt;
    logic [7:0]      hold_v_r, hold_v_nxt;
    logic            pix_ready_r, pix_ready_nxt;
    logic [7:0]      y_cur, u_cur, v_cur;
    logic            push;
    logic [31:0]     push_data;
    logic            fifo_in_ready;
    logic            fifo_ov;
    logic [31:0]     fifo_od;
    logic [LVL_W-1:0] fifo_lvl;
    logic            pop;
    byp_ser_t        ser_r, ser_nxt;
    logic [1:0]      idx_r, idx_nxt;
    logic [31:0]     word_r, word_nxt;
    logic [7:0]      out_byte_r, out_byte_nxt;
    logic            out_valid_r, out_valid_nxt;

    assign pix_ready = pix_ready_r;
    assign out_valid = out_valid_r;
    assign out_byte  = out_byte_r;

    // ------------------------------------------------------------------
    // Colour conversion of the registered full-colour pixel
    // ------------------------------------------------------------------
    // Same arithmetic for both formats
    always_comb begin
        y_cur = byp_conv(in_red_r, in_grn_r, in_blu_r, CY_R, CY_G, CY_B, Y_OFS);  // RL2 RL12
        u_cur = byp_conv(in_red_r, in_grn_r, in_blu_r, CU_R, CU_G, CU_B, C_OFS);  // RL3 RL5
        v_cur = byp_conv(in_red_r, in_grn_r, in_blu_r, CV_R, CV_G, CV_B, C_OFS);  // RL4 RL5
    end

    // ------------------------------------------------------------------
    // Input capture, pairing and packing
    // ------------------------------------------------------------------
    // Capture interpolated (or averaged) triples, pair them, pack per format
    always_comb begin
        in_vld_nxt    = pix_valid && pix_ready_r;  // RL1 RL11
        in_sof_nxt    = in_sof_r;
        in_red_nxt    = in_red_r;
        in_grn_nxt    = in_grn_r;
        in_blu_nxt    = in_blu_r;
        if (in_vld_nxt) begin
            in_sof_nxt = pix_sof;
            in_red_nxt = pix_red;
            in_grn_nxt = pix_green;
            in_blu_nxt = pix_blue;
        end
        odd_nxt    = odd_r;
        hold_y_nxt = hold_y_r;
        hold_u_nxt = hold_u_r;
        hold_v_nxt = hold_v_r;
        push       = 1'b0;
        if (in_vld_r) begin
            if (in_sof_r || !odd_r) begin
                hold_y_nxt = y_cur;
                hold_u_nxt = u_cur;  // RL8
                hold_v_nxt = v_cur;  // RL8
                odd_nxt    = 1'b1;
            end else begin
                push    = 1'b1;  // RL8
                odd_nxt = 1'b0;
            end
        end
        if (fmt_luma_first == FMT_LUMA_FIRST)
            push_data = {hold_y_r, hold_u_r, y_cur, hold_v_r};  // RL7
        else
            push_data = {hold_u_r, hold_y_r, hold_v_r, y_cur};  // RL6
        pix_ready_nxt = (fifo_lvl <= LVL_STOP);
    end

    // Input and pairing registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_vld_r    <= 1'b0;
            in_sof_r    <= 1'b0;
            in_red_r    <= 8'h00;
            in_grn_r    <= 8'h00;
            in_blu_r    <= 8'h00;
            odd_r       <= 1'b0;
            hold_y_r    <= 8'h00;
            hold_u_r    <= 8'h80;
            hold_v_r    <= 8'h80;
            pix_ready_r <= 1'b0;
        end else begin
            in_vld_r    <= in_vld_nxt;
            in_sof_r    <= in_sof_nxt;
            in_red_r    <= in_red_nxt;
            in_grn_r    <= in_grn_nxt;
            in_blu_r    <= in_blu_nxt;
            odd_r       <= odd_nxt;
            hold_y_r    <= hold_y_nxt;
            hold_u_r    <= hold_u_nxt;
            hold_v_r    <= hold_v_nxt;
            pix_ready_r <= pix_ready_nxt;
        end
    end

    byp_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_ov),
        .out_ready (pop),
        .out_data  (fifo_od),
        .level     (fifo_lvl)
    );

    // ------------------------------------------------------------------
    // Byte serializer
    // ------------------------------------------------------------------
    // Emit each pair word top lane first
    always_comb begin
        ser_nxt       = ser_r;
        idx_nxt       = idx_r;
        word_nxt      = word_r;
        out_byte_nxt  = out_byte_r;
        out_valid_nxt = out_valid_r;
        pop           = 1'b0;
        case (ser_r)
            SER_IDLE: begin
                if (fifo_ov) begin
                    pop           = 1'b1;
                    word_nxt      = fifo_od;
                    idx_nxt       = 2'h0;
                    out_byte_nxt  = byp_lane(fifo_od, 2'h0);
                    out_valid_nxt = 1'b1;
                    ser_nxt       = SER_SEND;
                end
            end
            SER_SEND: begin
                if (out_ready) begin
                    if (idx_r != IDX_LAST) begin
                        idx_nxt      = idx_r + 2'h1;
                        out_byte_nxt = byp_lane(word_r, idx_r + 2'h1);
                    end else if (fifo_ov) begin
                        pop          = 1'b1;
                        word_nxt     = fifo_od;
                        idx_nxt      = 2'h0;
                        out_byte_nxt = byp_lane(fifo_od, 2'h0);
                    end else begin
                        out_valid_nxt = 1'b0;
                        ser_nxt       = SER_IDLE;
                    end
                end
            end
            default: begin
                out_valid_nxt = 1'b0;
                ser_nxt       = SER_IDLE;
            end
        endcase
    end

    // Serializer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_r       <= SER_IDLE;
            idx_r       <= 2'h0;
            word_r      <= 32'h0000_0000;
            out_byte_r  <= 8'h00;
            out_valid_r <= 1'b0;
        end else begin
            ser_r       <= ser_nxt;
            idx_r       <= idx_nxt;
            word_r      <= word_nxt;
            out_byte_r  <= out_byte_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_rl1;
        @(posedge clk) disable iff (rst)
        (pix_valid && pix_ready) |=> in_vld_r && in_red_r == $past(pix_red);
    endproperty
    a_rl1: assert property (p_rl1) else $error("pixel triple not captured"); // RL1

    property p_rl2;
        @(posedge clk) disable iff (rst)
        (in_vld_r && in_red_r == in_grn_r && in_grn_r == in_blu_r) |-> y_cur == in_red_r;
    endproperty
    a_rl2: assert property (p_rl2) else $error("grey luma differs from input"); // RL2

    property p_rl3;
        @(posedge clk) disable iff (rst)
        (in_vld_r && in_red_r == 8'h00 && in_grn_r == 8'h00 && in_blu_r == 8'hFF)
            |-> u_cur == 8'hFF && v_cur == 8'h69;
    endproperty
    a_rl3: assert property (p_rl3) else $error("blue chroma wrong for pure blue"); // RL3

    property p_rl4;
        @(posedge clk) disable iff (rst)
        (in_vld_r && in_red_r == 8'hFF && in_grn_r == 8'h00 && in_blu_r == 8'h00)
            |-> v_cur == 8'hFF && u_cur == 8'h54;
    endproperty
    a_rl4: assert property (p_rl4) else $error("red chroma wrong for pure red"); // RL4

    property p_rl5;
        @(posedge clk) disable iff (rst)
        (in_vld_r && in_red_r == in_grn_r && in_grn_r == in_blu_r)
            |-> u_cur == 8'h80 && v_cur == 8'h80;
    endproperty
    a_rl5: assert property (p_rl5) else $error("grey chroma not at offset zero"); // RL5

    property p_rl6;
        @(posedge clk) disable iff (rst)
        (push && fmt_luma_first == FMT_CHROMA_FIRST) |-> byp_lane(push_data, 2'h0) == hold_u_r
            && byp_lane(push_data, 2'h1) == hold_y_r && byp_lane(push_data, 2'h3) == y_cur;
    endproperty
    a_rl6: assert property (p_rl6) else $error("chroma-first order wrong"); // RL6

    property p_rl7;
        @(posedge clk) disable iff (rst)
        (push && fmt_luma_first == FMT_LUMA_FIRST) |-> byp_lane(push_data, 2'h0) == hold_y_r
            && byp_lane(push_data, 2'h2) == y_cur && byp_lane(push_data, 2'h3) == hold_v_r;
    endproperty
    a_rl7: assert property (p_rl7) else $error("luma-first order wrong"); // RL7

    property p_rl8;
        @(posedge clk) disable iff (rst)
        push |-> in_vld_r && odd_r && !in_sof_r && fifo_in_ready;
    endproperty
    a_rl8: assert property (p_rl8) else $error("pair pushed from wrong pixel"); // RL8

    property p_rl13;
        @(posedge clk) disable iff (rst)
        (in_vld_r && in_red_r == 8'h00 && in_grn_r == 8'hFF && in_blu_r == 8'h00)
            |-> y_cur == 8'h96 && u_cur == 8'h2C && v_cur == 8'h17;
    endproperty
    a_rl13: assert property (p_rl13) else $error("rounding wrong for pure green"); // RL13
endmodule // byp_packer

// file: rtl/byp_pkg.sv
// Constants, types and conversion helpers for the Bayer-to-YUV 4:2:2 packer
// Overview of operation
// RL1: Accept only fully interpolated red, green, blue triples before any conversion.
// RL2: Luma equals 0.30 red plus 0.59 green plus 0.11 blue.
// RL3: Blue chroma equals -0.17 red, -0.33 green, +0.50 blue.
// RL4: Red chroma equals 0.50 red, -0.41 green, -0.09 blue.
// RL5: Add 128 to each signed chroma so it leaves as an unsigned byte.
// RL6: Chroma-first order per pair: U even, Y even, V even, Y odd.
// RL7: Luma-first order per pair: Y even, U even, Y odd, V even.
// RL8: Luma for every pixel; chroma once per pair, from the even pixel.
// RL9: Luma byte is unsigned, 0x00 level 0 up to 0xFF level 255.
// RL10: Chroma byte is offset binary, 0x80 zero, 0x00 minus 128, 0xFF plus 127.
// RL11: Conversion works on the averaged values that upstream delivers when averaging.
// RL12: Both formats share arithmetic, sampling and coding; only byte order differs.
// RL13: Round to nearest and saturate each result to 0..255 before packing.
package byp_pkg;

    // ------------------------------------------------------------------
    // Widths and buffering
    // ------------------------------------------------------------------
    localparam int BYTE_W     = 8;
    localparam int WORD_W     = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W      = 4;
    localparam logic [LVL_W-1:0] LVL_STOP = 4'h5;   // Highest level that still admits pixels
    localparam logic [1:0]       IDX_LAST = 2'h3;   // Last byte of a pair word

    // ------------------------------------------------------------------
    // Fixed-point coefficients, 8 fractional bits
    // ------------------------------------------------------------------
    localparam int                FRAC   = 8;
    localparam logic signed [9:0] CY_R   = 10'sh04D;   // 0.30
    localparam logic signed [9:0] CY_G   = 10'sh097;   // 0.59
    localparam logic signed [9:0] CY_B   = 10'sh01C;   // 0.11
    localparam logic signed [9:0] CU_R   = -10'sh02C;  // -0.17
    localparam logic signed [9:0] CU_G   = -10'sh054;  // -0.33
    localparam logic signed [9:0] CU_B   = 10'sh080;   // 0.50
    localparam logic signed [9:0] CV_R   = 10'sh080;   // 0.50
    localparam logic signed [9:0] CV_G   = -10'sh069;  // -0.41
    localparam logic signed [9:0] CV_B   = -10'sh017;  // -0.09
    localparam logic signed [19:0] ROUND = 20'sh00080;  // Half an LSB
    localparam logic signed [19:0] Y_OFS = 20'sh00000;
    localparam logic signed [19:0] C_OFS = 20'sh00080;  // Chroma offset of 128
    localparam logic signed [19:0] SAT_HI = 20'sh000FF;

    // ------------------------------------------------------------------
    // Formats and serializer states
    // ------------------------------------------------------------------
    localparam logic FMT_CHROMA_FIRST = 1'b0;  // chroma_first_422_format
    localparam logic FMT_LUMA_FIRST   = 1'b1;  // luma_first_422_format

    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SEND = 2'b10
    } byp_ser_t;

    // Weighted sum, rounding, offset and clamp to one byte
    function automatic logic [7:0] byp_conv(input logic [7:0] r, input logic [7:0] g,
                                            input logic [7:0] b, input logic signed [9:0] kr,
                                            input logic signed [9:0] kg,
                                            input logic signed [9:0] kb,
                                            input logic signed [19:0] ofs);
        logic signed [19:0] acc;
        acc = $signed({12'h000, r}) * 20'(kr) + $signed({12'h000, g}) * 20'(kg)
            + $signed({12'h000, b}) * 20'(kb);
        acc = (acc + ROUND) >>> FRAC;  // RL13
        acc = acc + ofs;  // RL5
        if (acc < 0)
            return 8'h00;  // RL13
        else if (acc > SAT_HI)
            return 8'hFF;  // RL13
        else
            return acc[7:0];  // RL9 RL10
    endfunction

    // Byte idx of a pair word, first byte in the top lane
    function automatic logic [7:0] byp_lane(input logic [31:0] w, input logic [1:0] idx);
        logic [31:0] sh;
        sh = w >> (5'(IDX_LAST - idx) * 5'h08);
        return sh[7:0];
    endfunction

endpackage

// file: verification/byp_host_sink.sv
// Frame transmitter model that takes packed bytes toward the host buffer
module byp_host_sink (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_byte,
    input  wire logic       hold_off,
    input  wire logic       slow,
    output logic            out_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got[$];
    logic       tick_r;

    // Collect bytes; stall fully or on alternate cycles when asked
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ready <= 1'b0;
            tick_r    <= 1'b0;
        end else begin
            if (out_valid && out_ready)
                got.push_back(out_byte);
            tick_r    <= ~tick_r;
            out_ready <= !hold_off && !(slow && tick_r);  // Slow host skips every other cycle
        end
    end
endmodule // byp_host_sink

// file: verification/testbench.sv
// Self-checking bench for the YUV 4:2:2 converter and byte packer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import byp_pkg::*;

    logic       clk = 1'b0;
    logic       rst, pix_valid, pix_ready, pix_sof, fmt_luma_first;
    logic       out_valid, out_ready, hold_off, slow;
    logic [7:0] pix_red, pix_green, pix_blue, out_byte;
    logic [7:0] exp_q[$];
    int         err_count, num_checks;

    // ------------------------------------------------------------------
    // Clock, design and host model
    // ------------------------------------------------------------------
    always #2.5 clk = ~clk;

    byp_packer DUT (.clk(clk), .rst(rst), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_sof(pix_sof), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
        .fmt_luma_first(fmt_luma_first), .out_valid(out_valid), .out_ready(out_ready),
        .out_byte(out_byte));

    byp_host_sink SINK (.clk(clk), .rst(rst), .out_valid(out_valid), .out_byte(out_byte),
        .hold_off(hold_off), .slow(slow), .out_ready(out_ready));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Q8 weighted sum, round half up, offset, clamp to a byte
    function automatic logic [7:0] ref_conv(input logic [7:0] r, g, b, input int kr, kg, kb,
                                            input int ofs);
        int acc;
        acc = ((int'(r) * kr + int'(g) * kg + int'(b) * kb + 128) >>> 8) + ofs;
        if (acc < 0)
            return 8'h00;
        if (acc > 255)
            return 8'hFF;
        return acc[7:0];
    endfunction

    // Queue the four bytes of one pair in the order of the chosen format
    task automatic exp_pair(input logic fmt, input logic [7:0] r0, g0, b0, r1, g1, b1);
        logic [7:0] y0, y1, u, v;
        y0 = ref_conv(r0, g0, b0, 77, 151, 28, 0);
        y1 = ref_conv(r1, g1, b1, 77, 151, 28, 0);
        u  = ref_conv(r0, g0, b0, -44, -84, 128, 128);
        v  = ref_conv(r0, g0, b0, 128, -105, -23, 128);
        if (fmt)
            exp_q = {exp_q, y0, u, y1, v};
        else
            exp_q = {exp_q, u, y0, v, y1};
    endtask

    // Offer one pixel and hold it until the edge that takes it
    task automatic send_pix(input logic [7:0] r, g, b, input logic sof);
        int n;
        pix_red   <= r;
        pix_green <= g;
        pix_blue  <= b;
        pix_sof   <= sof;
        pix_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                err_count++;
                test_done();
            end
        end while (pix_ready !== 1'b1);
    endtask

    task automatic send_pair(input logic fmt, input logic [7:0] r0, g0, b0, r1, g1, b1,
                             input logic sof);
        exp_pair(fmt, r0, g0, b0, r1, g1, b1);
        fmt_luma_first <= fmt;
        send_pix(r0, g0, b0, sof);
        send_pix(r1, g1, b1, 1'b0);
    endtask

    task automatic idle();
        pix_valid <= 1'b0;
        pix_sof   <= 1'b0;
        @(posedge clk);
    endtask

    // Wait for every expected byte, then compare the whole stream
    task automatic drain(input string name);
        int n;
        idle();
        n = 0;
        while (SINK.got.size() < exp_q.size()) begin
            @(posedge clk);
            n++;
            if (n > 500) begin
                err_count++;
                test_done();
            end
        end
        repeat (8) @(posedge clk);
        check(SINK.got.size(), exp_q.size(), "byte count");
        foreach (exp_q[i])
            check(SINK.got[i], exp_q[i], "packed byte");
        $display("Test %s done", name);
        exp_q.delete();
        SINK.got.delete();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Grey levels give Y equal to input and both chroma at the zero code
    task automatic t_grey();
        send_pair(1'b0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 1'b1);
        send_pair(1'b0, 8'h80, 8'h80, 8'h80, 8'h01, 8'h01, 8'h01, 1'b0);
        drain("grey");
    endtask

    // Saturating and mixed colours in both byte orders, slow host on the second
    task automatic t_colours();
        logic [23:0] tbl[6];
        tbl = '{24'hFF0000, 24'h0000FF, 24'h00FF00, 24'hFFFFFF, 24'h123456, 24'hC840A0};
        for (int f = 0; f < 2; f++) begin
            slow <= f[0];
            for (int i = 0; i < 6; i += 2)
                send_pair(f[0], tbl[i][23:16], tbl[i][15:8], tbl[i][7:0],
                          tbl[i+1][23:16], tbl[i+1][15:8], tbl[i+1][7:0], i == 0);
            drain(f ? "luma first" : "chroma first");
        end
        slow <= 1'b0;
    endtask

    // A lone even pixel cut off by a new start yields no bytes
    task automatic t_sof();
        send_pix(8'hFF, 8'h00, 8'h00, 1'b1);
        send_pair(1'b1, 8'h20, 8'h90, 8'h40, 8'h70, 8'h10, 8'hE0, 1'b1);
        drain("restart");
    endtask

    // Host stalls for 80 cycles so the buffer refuses pixels, then drains it all
    task automatic t_fill();
        int refused;
        refused  = 0;
        hold_off <= 1'b1;
        fork
            begin
                for (int i = 0; i < 12; i++)
                    send_pair(1'b0, 8'(i * 20), 8'h40, 8'(255 - i * 20), 8'h10, 8'(i * 9),
                              8'h80, i == 0);
                idle();
            end
            begin
                repeat (80) begin
                    @(posedge clk);
                    if (pix_valid === 1'b1 && pix_ready === 1'b0)
                        refused++;
                end
                check(SINK.got.size(), 0, "bytes while host stalled");
                check(refused > 0, 1, "buffer never refused");
                hold_off <= 1'b0;
            end
        join
        drain("fill");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst            = 1'b1;
        pix_valid      = 1'b0;
        pix_sof        = 1'b0;
        pix_red        = 8'h00;
        pix_green      = 8'h00;
        pix_blue       = 8'h00;
        fmt_luma_first = 1'b0;
        hold_off       = 1'b0;
        slow           = 1'b0;
        err_count      = 0;
        num_checks     = 0;
        repeat (8) @(posedge clk);
        check(out_valid, 1'b0, "out_valid in reset");
        check(pix_ready, 1'b0, "pix_ready in reset");
        rst <= 1'b0;
        @(posedge clk);
        t_grey();
        t_colours();
        t_sof();
        t_fill();
        test_done();
    end
endmodule // testbench
